//--- hdl/gpio_event_irq.sv
`timescale 1ns/100ps
`include "gpio_irq_regs.svh"
module gpio_event_irq
    import gpio_irq_pkg::*;
(
    input  wire logic       MCLK_I,
    input  wire logic       RSTN_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic       WR_EN_I,
    input  wire logic       RD_EN_I,
    input  wire logic [7:0] WDATA_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       GEN_PIN_ONE_I,
    output logic            GEN_PIN_ONE_O,
    output logic            GEN_PIN_ONE_OE_O,
    input  wire logic       GEN_PIN_TWO_I,
    output logic            GEN_PIN_TWO_O,
    output logic            GEN_PIN_TWO_OE_O,
    input  wire logic       GEN_PIN_THREE_I,
    output logic            GEN_PIN_THREE_O,
    output logic            GEN_PIN_THREE_OE_O,
    input  wire logic [7:0] PG_FAULT_I,
    input  wire logic       THERMAL_I,
    input  wire logic       ADC_DONE_I,
    input  wire logic       ADC_ABOVE_I,
    input  wire logic       ADC_BELOW_I,
    input  wire logic       BAT_TAG_I,
    input  wire logic [1:0] CHG_STATE_I,
    output logic            BUCK_ONE_EN_O,
    output logic            BUCK_TWO_EN_O,
    output logic            BUCK_STANDBY_O,
    output logic            ADC_START_O,
    output logic            ADC_SLEEP_O,
    output logic            HOST_IRQ_O
);
    logic [7:0]    mask_pg_reg;
    logic [7:0]    mask_misc_reg;
    logic [7:0]    sleep_en_reg;
    logic [7:0]    pin_cfg12_reg;
    logic [7:0]    pin_cfg3_reg;
    logic [7:0]    pg_ack_reg;
    logic [7:0]    misc_ack_reg;
    logic [8:0]    flt_meta_reg;
    logic [8:0]    flt_sync_reg;
    logic          thermal_prev_reg;
    logic [1:0]    chg_prev_reg;
    logic          chg_valid_reg;
    logic [2:0]    pin_raw;
    logic [2:0]    pin_lvl;
    logic [2:0]    pin_edge;
    logic [2:0]    pin_rise;
    logic [2:0]    pin_in;
    logic [7:0]    pg_fault_sync;
    logic          thermal_sync;
    pin_one_func_t p1_func;
    pin_two_func_t p2_func;
    logic          rd_pg;
    logic          rd_misc;
    logic [7:0]    pg_set;
    logic [7:0]    misc_set;
    logic [7:0]    rdata_next;
    logic          irq_next;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target, input logic en);
        addr_hit = en && (a == target);
    endfunction

    assign pin_raw  = {GEN_PIN_THREE_I, GEN_PIN_TWO_I, GEN_PIN_ONE_I};
    assign pin_in   = ~{pin_cfg3_reg[`P3_DIR_BIT], pin_cfg12_reg[`P2_DIR_BIT], pin_cfg12_reg[`P1_DIR_BIT]};
    assign pin_rise = {1'b1, pin_cfg12_reg[`P2_RISE_BIT], pin_cfg12_reg[`P1_RISE_BIT]};
    assign p1_func  = pin_one_func_t'(pin_cfg3_reg[`P1_FUNC_MSB:`P1_FUNC_LSB]);
    assign p2_func  = pin_two_func_t'(pin_cfg3_reg[`P2_FUNC_BIT]);

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_pin
            pin_sync_edge u_sync (
                .clk_i      (MCLK_I),
                .rst_n_i    (RSTN_I),
                .pin_i      (pin_raw[g]),
                .rise_sel_i (pin_rise[g]),
                .level_o    (pin_lvl[g]),
                .edge_o     (pin_edge[g])
            );
        end
    endgenerate

    // analog comparator levels arrive unsynchronised
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flt_meta_reg     <= 9'h000;
            flt_sync_reg     <= 9'h000;
            thermal_prev_reg <= 1'b0;
        end else begin
            flt_meta_reg     <= {THERMAL_I, PG_FAULT_I};
            flt_sync_reg     <= flt_meta_reg;
            thermal_prev_reg <= flt_sync_reg[8];
        end
    end

    assign pg_fault_sync = flt_sync_reg[7:0];
    assign thermal_sync  = flt_sync_reg[8];

    // charger state is on-chip logic on this clock; first sample only arms the compare
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            chg_prev_reg  <= 2'b00;
            chg_valid_reg <= 1'b0;
        end else begin
            chg_prev_reg  <= CHG_STATE_I;
            chg_valid_reg <= 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mask_pg_reg   <= `RST_MASK;
            mask_misc_reg <= `RST_MASK;
            sleep_en_reg  <= `RST_SLEEP_EN;
            pin_cfg12_reg <= `RST_PIN_CFG12;
            pin_cfg3_reg  <= `RST_PIN_CFG3;
        end else begin
            if (addr_hit(ADDR_I, `ADDR_MASK_PG, WR_EN_I)) begin
                mask_pg_reg <= WDATA_I;
            end
            if (addr_hit(ADDR_I, `ADDR_MASK_MISC, WR_EN_I)) begin
                mask_misc_reg <= WDATA_I;
            end
            if (addr_hit(ADDR_I, `ADDR_SLEEP_EN, WR_EN_I)) begin
                sleep_en_reg <= WDATA_I;
            end
            if (addr_hit(ADDR_I, `ADDR_PIN_CFG12, WR_EN_I)) begin
                pin_cfg12_reg <= WDATA_I;
            end
            if (addr_hit(ADDR_I, `ADDR_PIN_CFG3, WR_EN_I)) begin
                pin_cfg3_reg <= WDATA_I;
            end
        end
    end

    // event sources
    assign pg_set = pg_fault_sync;
    always_comb begin
        misc_set                    = 8'h00;
        misc_set[`EV_ADC_DONE_BIT]  = ADC_DONE_I & ~ADC_ABOVE_I & ~ADC_BELOW_I;
        misc_set[`EV_BAT_TAG_BIT]   = BAT_TAG_I;
        misc_set[`EV_PIN_ONE_BIT]   = pin_in[0] & pin_cfg12_reg[`P1_IRQ_EN_BIT] & pin_edge[0];
        misc_set[`EV_PIN_TWO_BIT]   = pin_in[1] & pin_cfg12_reg[`P2_IRQ_EN_BIT] & pin_edge[1];
        misc_set[`EV_THERMAL_BIT]   = thermal_sync & ~thermal_prev_reg;
        misc_set[`EV_CHG_BIT]       = chg_valid_reg & (CHG_STATE_I != chg_prev_reg);
        misc_set[`EV_ADC_UPPER_BIT] = ADC_ABOVE_I;
        misc_set[`EV_ADC_LOWER_BIT] = ADC_BELOW_I;
    end

    assign rd_pg   = addr_hit(ADDR_I, `ADDR_PG_EVENTS, RD_EN_I);
    assign rd_misc = addr_hit(ADDR_I, `ADDR_MISC_EVENTS, RD_EN_I);

    // a set in the read cycle survives the clear, so no event is lost
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pg_ack_reg   <= `RST_EVENTS;
            misc_ack_reg <= `RST_EVENTS;
        end else begin
            pg_ack_reg   <= pg_set | (pg_ack_reg & ~{8{rd_pg}});
            misc_ack_reg <= misc_set | (misc_ack_reg & ~{8{rd_misc}});
        end
    end

    always_comb begin
        rdata_next = `READ_ZERO;
        unique case (ADDR_I)
            `ADDR_MASK_PG:     rdata_next = mask_pg_reg;
            `ADDR_MASK_MISC:   rdata_next = mask_misc_reg;
            `ADDR_PG_EVENTS:   rdata_next = pg_ack_reg;
            `ADDR_MISC_EVENTS: rdata_next = misc_ack_reg;
            `ADDR_SLEEP_EN:    rdata_next = sleep_en_reg;
            `ADDR_PIN_CFG12:   rdata_next = pin_cfg12_reg;
            `ADDR_PIN_CFG3:    rdata_next = pin_cfg3_reg;
            default:           rdata_next = `READ_ZERO;
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= `READ_ZERO;
        end else if (RD_EN_I) begin
            RDATA_O <= rdata_next;
        end
    end

    // pin drivers
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            GEN_PIN_ONE_O      <= 1'b0;
            GEN_PIN_ONE_OE_O   <= 1'b0;
            GEN_PIN_TWO_O      <= 1'b0;
            GEN_PIN_TWO_OE_O   <= 1'b0;
            GEN_PIN_THREE_O    <= 1'b0;
            GEN_PIN_THREE_OE_O <= 1'b0;
        end else begin
            GEN_PIN_ONE_O      <= pin_cfg12_reg[`P1_LVL_BIT];
            GEN_PIN_ONE_OE_O   <= ~pin_in[0];
            GEN_PIN_TWO_O      <= pin_cfg12_reg[`P2_LVL_BIT];
            GEN_PIN_TWO_OE_O   <= ~pin_in[1];
            GEN_PIN_THREE_O    <= pin_cfg3_reg[`P3_LVL_BIT];
            GEN_PIN_THREE_OE_O <= ~pin_in[2];
        end
    end

    // converter control from input pins; an unused code drives buck one enable and standby low
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            BUCK_ONE_EN_O  <= 1'b0;
            BUCK_STANDBY_O <= 1'b0;
        end else begin
            BUCK_ONE_EN_O  <= 1'b0;
            BUCK_STANDBY_O <= 1'b0;
            unique case (p1_func)
                P1_FUNC_BUCK_EN:  BUCK_ONE_EN_O  <= pin_in[0] & pin_lvl[0];
                P1_FUNC_STANDBY:  BUCK_STANDBY_O <= pin_in[0] & pin_lvl[0];
                P1_FUNC_IRQ_ONLY: BUCK_ONE_EN_O  <= 1'b0;
                default:          BUCK_ONE_EN_O  <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            BUCK_TWO_EN_O <= 1'b0;
        end else begin
            BUCK_TWO_EN_O <= pin_in[1] & (p2_func == P2_FUNC_BUCK_EN) & pin_lvl[1];
        end
    end

    // adc start is a one-cycle pulse per rising edge of input pin three
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ADC_START_O <= 1'b0;
            ADC_SLEEP_O <= 1'b0;
        end else begin
            ADC_START_O <= pin_in[2] & pin_edge[2];
            ADC_SLEEP_O <= |(pg_fault_sync & sleep_en_reg);
        end
    end

    // level interrupt: drops only once every unmasked bit is read away
    assign irq_next = |(pg_ack_reg & ~mask_pg_reg) | |(misc_ack_reg & ~mask_misc_reg);

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            HOST_IRQ_O <= 1'b0;
        end else begin
            HOST_IRQ_O <= irq_next;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_p1_rise;
        !pin_lvl[0] ##1 pin_lvl[0];
    endsequence

    sequence s_p1_armed;
        pin_in[0] && pin_cfg12_reg[`P1_IRQ_EN_BIT] && pin_cfg12_reg[`P1_RISE_BIT];
    endsequence

    a_pin_one_drive: assert property (
        !pin_in[0] |=> GEN_PIN_ONE_OE_O && GEN_PIN_ONE_O == $past(pin_cfg12_reg[`P1_LVL_BIT]))
        else $error("pin one not driven to its level");
    a_pin_three_release: assert property (
        pin_in[2] |=> !GEN_PIN_THREE_OE_O)
        else $error("input pin three still driven");
    a_p1_rise_event: assert property (
        (s_p1_rise ##0 s_p1_armed) |=> misc_ack_reg[`EV_PIN_ONE_BIT])
        else $error("rising edge on pin one lost");
    a_p2_edge_event: assert property (
        pin_in[1] && pin_cfg12_reg[`P2_IRQ_EN_BIT] && pin_edge[1] |=> misc_ack_reg[`EV_PIN_TWO_BIT] ##1 HOST_IRQ_O
            || $past(mask_misc_reg[`EV_PIN_TWO_BIT]))
        else $error("pin two edge not reported");
    a_buck_one_pin: assert property (
        pin_in[0] && p1_func == P1_FUNC_BUCK_EN |=> BUCK_ONE_EN_O == $past(pin_lvl[0]) && !BUCK_STANDBY_O)
        else $error("buck one enable does not follow pin one");
    a_buck_two_pin: assert property (
        !pin_in[1] |=> !BUCK_TWO_EN_O)
        else $error("buck two enabled from an output pin");
    a_adc_start: assert property (
        pin_in[2] && pin_edge[2] |=> ADC_START_O ##1 !ADC_START_O)
        else $error("adc start pulse wrong");
    a_adc_sleep: assert property (
        (pg_fault_sync & sleep_en_reg) == 8'h00 |=> !ADC_SLEEP_O)
        else $error("adc asleep without enabled fault");
    a_pg_read_clear: assert property (
        rd_pg && pg_set == 8'h00 |=> pg_ack_reg == 8'h00)
        else $error("power-good events not cleared by read");
    a_pg_fault_set: assert property (
        pg_fault_sync[`PG_BUCK_ONE_BIT] |=> pg_ack_reg[`PG_BUCK_ONE_BIT]
            ##1 (HOST_IRQ_O || $past(mask_pg_reg[`PG_BUCK_ONE_BIT])))
        else $error("buck one fault not latched");
    a_adc_done_clean: assert property (
        ADC_DONE_I && (ADC_ABOVE_I || ADC_BELOW_I) && !misc_ack_reg[`EV_ADC_DONE_BIT] |=> !misc_ack_reg[`EV_ADC_DONE_BIT])
        else $error("done set on a limit crossing");
    a_charge_change: assert property (
        chg_valid_reg && CHG_STATE_I != chg_prev_reg |=> misc_ack_reg[`EV_CHG_BIT])
        else $error("charge state change missed");
    a_irq_quiet: assert property (
        !irq_next ##1 !irq_next |=> !HOST_IRQ_O)
        else $error("interrupt with no unmasked event");
endmodule

//--- hdl/pin_sync_edge.sv
`timescale 1ns/100ps
module pin_sync_edge (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    input  wire logic rise_sel_i,
    output logic      level_o,
    output logic      edge_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // meta_reg feeds sync_reg only; edges come from the settled pair
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign edge_o  = rise_sel_i ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
endmodule

//--- include/gpio_irq_pkg.sv
package gpio_irq_pkg;

    typedef enum logic [1:0] {
        P1_FUNC_BUCK_EN  = 2'b00,
        P1_FUNC_STANDBY  = 2'b01,
        P1_FUNC_IRQ_ONLY = 2'b10
    } pin_one_func_t;

    typedef enum logic {
        P2_FUNC_BUCK_EN  = 1'b0,
        P2_FUNC_IRQ_ONLY = 1'b1
    } pin_two_func_t;

endpackage

//--- include/gpio_irq_regs.svh
`ifndef GPIO_IRQ_REGS_SVH
`define GPIO_IRQ_REGS_SVH

// register addresses on the 8-bit register port
`define ADDR_MASK_PG      8'h03
`define ADDR_MASK_MISC    8'h04
`define ADDR_PG_EVENTS    8'h05
`define ADDR_MISC_EVENTS  8'h06
`define ADDR_SLEEP_EN     8'h07
`define ADDR_PIN_CFG12    8'h1b
`define ADDR_PIN_CFG3     8'h1c

// reset values
`define RST_MASK          8'h00
`define RST_SLEEP_EN      8'h00
`define RST_PIN_CFG12     8'h00
`define RST_PIN_CFG3      8'h00
`define RST_EVENTS        8'h00
`define READ_ZERO         8'h00

// pin_cfg12 fields
`define P1_DIR_BIT        0
`define P1_LVL_BIT        1
`define P1_RISE_BIT       2
`define P2_DIR_BIT        3
`define P2_LVL_BIT        4
`define P2_RISE_BIT       5
`define P1_IRQ_EN_BIT     6
`define P2_IRQ_EN_BIT     7

// pin_cfg3 fields
`define P3_DIR_BIT        0
`define P3_LVL_BIT        1
`define P1_FUNC_LSB       2
`define P1_FUNC_MSB       3
`define P2_FUNC_BIT       4

// power_good_events bits: buck one..three, then linear regs 1..5
`define PG_BUCK_ONE_BIT   0
`define PG_BUCK_TWO_BIT   1
`define PG_BUCK_THREE_BIT 2

// misc_events bits
`define EV_ADC_DONE_BIT   0
`define EV_BAT_TAG_BIT    1
`define EV_PIN_ONE_BIT    2
`define EV_PIN_TWO_BIT    3
`define EV_THERMAL_BIT    4
`define EV_CHG_BIT        5
`define EV_ADC_UPPER_BIT  6
`define EV_ADC_LOWER_BIT  7

`endif

//--- verif/gpio_event_irq_tb.sv
`timescale 1ns/100ps
`include "gpio_irq_regs.svh"
module gpio_event_irq_tb;
    logic       clk;
    logic       rst_n;
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] gp_in;
    logic [2:0] gp_o;
    logic [2:0] gp_oe;
    logic [7:0] pg_fault;
    logic       thermal;
    logic       adc_done;
    logic       adc_above;
    logic       adc_below;
    logic       bat_tag;
    logic [1:0] chg_state;
    logic [2:0] bucks;
    logic       adc_start;
    logic       adc_sleep;
    logic       host_irq;
    int         bad_count;
    int         checks;
    int         evs [6] = '{0, 1, 4, 5, 6, 7};
    logic [7:0] regs [7] = '{`ADDR_MASK_PG, `ADDR_MASK_MISC, `ADDR_PG_EVENTS, `ADDR_MISC_EVENTS,
                             `ADDR_SLEEP_EN, `ADDR_PIN_CFG12, `ADDR_PIN_CFG3};

    gpio_event_irq u_gpio_event_irq (
        .MCLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WR_EN_I(wr_en), .RD_EN_I(rd_en),
        .WDATA_I(wdata), .RDATA_O(rdata),
        .GEN_PIN_ONE_I(gp_in[0]), .GEN_PIN_ONE_O(gp_o[0]), .GEN_PIN_ONE_OE_O(gp_oe[0]),
        .GEN_PIN_TWO_I(gp_in[1]), .GEN_PIN_TWO_O(gp_o[1]), .GEN_PIN_TWO_OE_O(gp_oe[1]),
        .GEN_PIN_THREE_I(gp_in[2]), .GEN_PIN_THREE_O(gp_o[2]), .GEN_PIN_THREE_OE_O(gp_oe[2]),
        .PG_FAULT_I(pg_fault), .THERMAL_I(thermal), .ADC_DONE_I(adc_done), .ADC_ABOVE_I(adc_above),
        .ADC_BELOW_I(adc_below), .BAT_TAG_I(bat_tag), .CHG_STATE_I(chg_state),
        .BUCK_ONE_EN_O(bucks[0]), .BUCK_TWO_EN_O(bucks[1]), .BUCK_STANDBY_O(bucks[2]),
        .ADC_START_O(adc_start), .ADC_SLEEP_O(adc_sleep), .HOST_IRQ_O(host_irq)
    );
    host_model u_host_model (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_en_o(wr_en), .rd_en_o(rd_en), .wdata_o(wdata)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host_model.reg_write(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host_model.reg_read(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask
    // sel 1 waits for the adc start pulse, sel 0 for the interrupt line
    task automatic wait_sig(input bit sel);
        int n;
        n = 0;
        while ((sel ? adc_start : host_irq) !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if ((sel ? adc_start : host_irq) !== 1'b1) begin
            bad_count++;
            $display("[ERR] %s expected 1 seen 0", sel ? "adc_start" : "host_irq");
            test_done();
        end
    endtask
    task automatic fire(input int k);
        @(negedge clk);
        case (k)
            0: adc_done = 1'b1;
            1: bat_tag = 1'b1;
            4: thermal = 1'b1;
            5: chg_state = chg_state + 2'd1;
            6: {adc_done, adc_above} = 2'b11;
            default: adc_below = 1'b1;
        endcase
        @(negedge clk);
        {adc_done, bat_tag, adc_above, adc_below} = 4'h0;
        cycles(4);
        thermal = 1'b0;
    endtask

    initial begin
        {rst_n, gp_in, pg_fault, thermal, adc_done, adc_above, adc_below, bat_tag, chg_state} = '0;
        bad_count = 0;
        checks = 0;
        cycles(12);
        rst_n = 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        chk("pin oe", 8'h00, 8'(gp_oe));
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        wr(`ADDR_MISC_EVENTS, 8'hff);
        rd(`ADDR_MISC_EVENTS, 8'h00);
        // outputs with irq enables set: pin activity must stay invisible
        wr(`ADDR_PIN_CFG3, 8'h03);
        wr(`ADDR_PIN_CFG12, 8'hcb);
        cycles(3);
        chk("pin oe", 8'h07, 8'(gp_oe));
        chk("pin out", 8'h05, 8'(gp_o));
        gp_in = 3'b111;
        cycles(8);
        chk("bucks", 8'h00, 8'(bucks));
        wr(`ADDR_PIN_CFG12, 8'hd9);
        wr(`ADDR_PIN_CFG3, 8'h01);
        cycles(3);
        chk("pin out", 8'h02, 8'(gp_o));
        rd(`ADDR_MISC_EVENTS, 8'h00);
        gp_in = 3'b000;
        cycles(4);
        wr(`ADDR_PIN_CFG12, 8'hc4);
        wr(`ADDR_PIN_CFG3, 8'h00);
        cycles(3);
        chk("pin oe", 8'h00, 8'(gp_oe));
        // pin one on rising, pin two on falling
        gp_in[1] = 1'b1;
        cycles(8);
        chk("host_irq", 8'h00, 8'(host_irq));
        gp_in[0] = 1'b1;
        wait_sig(1'b0);
        rd(`ADDR_MISC_EVENTS, 8'h04);
        cycles(3);
        chk("host_irq", 8'h00, 8'(host_irq));
        gp_in[1] = 1'b0;
        wait_sig(1'b0);
        rd(`ADDR_MISC_EVENTS, 8'h08);
        gp_in[0] = 1'b0;
        cycles(8);
        rd(`ADDR_MISC_EVENTS, 8'h00);
        // pin control of the bucks, irq sources off
        wr(`ADDR_PIN_CFG12, 8'h00);
        gp_in[0] = 1'b1;
        cycles(4);
        chk("bucks", 8'h01, 8'(bucks));
        wr(`ADDR_PIN_CFG3, 8'h04);
        cycles(3);
        chk("bucks", 8'h04, 8'(bucks));
        gp_in[1] = 1'b1;
        wr(`ADDR_PIN_CFG3, 8'h08);
        cycles(3);
        chk("bucks", 8'h02, 8'(bucks));
        wr(`ADDR_PIN_CFG3, 8'h18);
        cycles(3);
        chk("bucks", 8'h00, 8'(bucks));
        chk("host_irq", 8'h00, 8'(host_irq));
        gp_in = 3'b000;
        cycles(4);
        gp_in[2] = 1'b1;
        wait_sig(1'b1);
        @(negedge clk);
        chk("adc_start", 8'h00, 8'(adc_start));
        foreach (evs[i]) begin
            fire(evs[i]);
            wait_sig(1'b0);
            rd(`ADDR_MISC_EVENTS, 8'h01 << evs[i]);
            cycles(3);
            chk("host_irq", 8'h00, 8'(host_irq));
        end
        wr(`ADDR_MASK_MISC, 8'h01);
        fire(0);
        cycles(4);
        chk("host_irq", 8'h00, 8'(host_irq));
        rd(`ADDR_MISC_EVENTS, 8'h01);
        wr(`ADDR_MASK_MISC, 8'h00);
        wr(`ADDR_SLEEP_EN, 8'haa);
        for (int i = 0; i < 8; i++) begin
            pg_fault = 8'h01 << i;
            wait_sig(1'b0);
            cycles(1);
            chk("adc_sleep", 8'(i % 2), 8'(adc_sleep));
            pg_fault = 8'h00;
            cycles(4);
            rd(`ADDR_PG_EVENTS, 8'h01 << i);
            cycles(3);
            chk("host_irq", 8'h00, 8'(host_irq));
        end
        wr(`ADDR_MASK_PG, 8'h10);
        pg_fault = 8'h10;
        cycles(8);
        chk("host_irq", 8'h00, 8'(host_irq));
        wr(`ADDR_MASK_PG, 8'h00);
        wait_sig(1'b0);
        pg_fault = 8'h00;
        cycles(4);
        rd(`ADDR_PG_EVENTS, 8'h10);
        rd(`ADDR_PG_EVENTS, 8'h00);
        // pin one on falling, pin two on rising
        wr(`ADDR_PIN_CFG12, 8'he0);
        gp_in[1:0] = 2'b11;
        wait_sig(1'b0);
        rd(`ADDR_MISC_EVENTS, 8'h08);
        gp_in[0] = 1'b0;
        wait_sig(1'b0);
        rd(`ADDR_MISC_EVENTS, 8'h04);
        test_done();
    end
endmodule

//--- verif/host_model.sv
`timescale 1ns/100ps
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] wdata_o
);
    // released bus shows the inverse so a stale value never looks valid
    initial begin
        addr_o  = 8'hff;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wdata_o = 8'hff;
    end
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o  = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o  = a;
        rd_en_o = 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        rd_en_o = 1'b0;
        addr_o  = ~a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule
